//--- core/ddtf_consts.svh
`ifndef DDTF_CONSTS_SVH
`define DDTF_CONSTS_SVH

// Register offsets, byte addresses on the plain port
`define DDTF_ADDR_W 8
`define DDTF_OFF_STATUS 8'h00
`define DDTF_OFF_RX_WORD 8'h04
`define DDTF_OFF_TX_WORD 8'h08
`define DDTF_OFF_IRQ_STS 8'h0c
`define DDTF_OFF_IRQ_MASK 8'h10

// Status and control field positions
`define DDTF_BIT_RX_LIVE 0
`define DDTF_BIT_TX_LIVE 1
`define DDTF_BIT_RX_LAT 2
`define DDTF_BIT_TX_LAT 3
`define DDTF_MODE_LSB 4
`define DDTF_MODE_MSB 5

// Channel mode encodings and reset values
`define DDTF_MODE_NONBLOCK 2'h0
`define DDTF_MODE_RESET 2'h0
`define DDTF_WORD_RESET 32'h0000_0000

// Interrupt event bits
`define DDTF_EVT_W 4
`define DDTF_EVT_RX_DROP 0
`define DDTF_EVT_TX_REFUSE 1
`define DDTF_EVT_RX_ARRIVE 2
`define DDTF_EVT_TX_DRAIN 3
`define DDTF_EVT_RESET 4'h0

`endif

//--- core/ddtf_pkg.sv
package ddtf_pkg;
    typedef logic [31:0] ddtf_word_type;
    typedef logic [7:0] ddtf_addr_type;
    typedef logic [1:0] ddtf_mode_type;
    typedef logic [3:0] ddtf_evt_type;
endpackage

//--- core/ddtf_word_store.sv
`timescale 1ns/100ps
`default_nettype none
`include "ddtf_consts.svh"

module ddtf_word_store (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_wr,
    input wire ddtf_pkg::ddtf_word_type i_wdata,
    output ddtf_pkg::ddtf_word_type o_word
);
    import ddtf_pkg::*;

    ddtf_word_type word_reg;
    ddtf_word_type word_next;

    // Hold the word unless a write is accepted
    always_comb begin
        word_next = i_wr ? i_wdata : word_reg;
    end

    // Storage flop, read straight out
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            word_reg <= `DDTF_WORD_RESET;
        end else begin
            word_reg <= word_next;
        end
    end

    assign o_word = word_reg;
endmodule

`default_nettype wire

//--- core/ddtf_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ddtf_consts.svh"

// Functional notes
// - In non-blocking mode keep latched rx/tx full flags gating debugger.
// - Core read of rx word clears live rx full; latched stays in non-blocking mode, follows live in blocking modes.
// - Debugger rx write is ignored while latched rx full is set.
// - Debugger status read copies live rx full into latched rx full.
// - Debugger rx write also refreshes latched rx full from live.
// - Status read or tx word read refreshes latched tx full.
module ddtf_top (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire ddtf_pkg::ddtf_addr_type i_addr,
    input wire ddtf_pkg::ddtf_word_type i_wdata,
    input wire logic i_we,
    input wire logic i_re,
    output ddtf_pkg::ddtf_word_type o_rdata,
    input wire logic i_core_rx_rd,
    output ddtf_pkg::ddtf_word_type o_core_rx_word,
    input wire logic i_core_tx_wr,
    input wire ddtf_pkg::ddtf_word_type i_core_tx_word,
    output logic o_rx_full_live,
    output logic o_tx_full_live,
    output logic o_irq
);
    import ddtf_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State and decode

    logic rx_live_reg, rx_live_next;
    logic tx_live_reg, tx_live_next;
    logic rx_lat_reg, rx_lat_next;
    logic tx_lat_reg, tx_lat_next;
    ddtf_mode_type mode_reg, mode_next;
    ddtf_evt_type sts_reg, sts_next;
    ddtf_evt_type mask_reg, mask_next;
    ddtf_word_type rdata_reg, rdata_next;
    logic irq_reg, irq_next;
    ddtf_word_type rx_word;
    ddtf_word_type tx_word;
    ddtf_evt_type evt;
    logic nb, sts_rd, rx_wr, tx_rd, rx_gate, tx_gate, rx_accept, tx_take;

    // Access decode; gate flags depend on the channel mode
    always_comb begin
        nb = (mode_reg == `DDTF_MODE_NONBLOCK);
        sts_rd = i_re && (i_addr == `DDTF_OFF_STATUS);
        rx_wr = i_we && (i_addr == `DDTF_OFF_RX_WORD);
        tx_rd = i_re && (i_addr == `DDTF_OFF_TX_WORD);
        // Blocking modes gate on the live flags instead
        rx_gate = nb ? rx_lat_reg : rx_live_reg;
        tx_gate = nb ? tx_lat_reg : tx_live_reg;
        rx_accept = rx_wr && !rx_gate;
        tx_take = tx_rd && tx_gate;
    end

    ////////////////////////////////////////////////////////////////////////
    // Data words

    ddtf_word_store u_rx_store (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_wr(rx_accept),
        .i_wdata(i_wdata),
        .o_word(rx_word)
    );

    ddtf_word_store u_tx_store (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_wr(i_core_tx_wr),
        .i_wdata(i_core_tx_word),
        .o_word(tx_word)
    );

    ////////////////////////////////////////////////////////////////////////
    // Flag next state; sets win over clears in the same cycle

    always_comb begin
        rx_live_next = rx_live_reg;
        if (i_core_rx_rd) begin
            rx_live_next = 1'b0;
        end
        if (rx_accept) begin
            rx_live_next = 1'b1;
        end
        tx_live_next = tx_live_reg;
        if (tx_take) begin
            tx_live_next = 1'b0;
        end
        if (i_core_tx_wr) begin
            tx_live_next = 1'b1;
        end
        // In non-blocking mode latched copies move only on debugger accesses; blocking modes copy live every cycle
        rx_lat_next = rx_lat_reg;
        tx_lat_next = tx_lat_reg;
        if (!nb) begin
            rx_lat_next = rx_live_next;
            tx_lat_next = tx_live_next;
        end else if (sts_rd) begin
            rx_lat_next = rx_live_reg;
            tx_lat_next = tx_live_reg;
        end else if (rx_wr) begin
            // Stops a second unseen write sneaking in
            rx_lat_next = rx_live_next;
        end else if (tx_rd) begin
            tx_lat_next = tx_live_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers, interrupt and read data

    always_comb begin
        evt = `DDTF_EVT_RESET;
        evt[`DDTF_EVT_RX_DROP] = rx_wr && rx_gate;
        evt[`DDTF_EVT_TX_REFUSE] = tx_rd && !tx_gate;
        evt[`DDTF_EVT_RX_ARRIVE] = rx_accept;
        evt[`DDTF_EVT_TX_DRAIN] = tx_take;
        mode_next = mode_reg;
        mask_next = mask_reg;
        sts_next = sts_reg;
        if (i_we && i_addr == `DDTF_OFF_STATUS) begin
            mode_next = i_wdata[`DDTF_MODE_MSB:`DDTF_MODE_LSB];
        end
        if (i_we && i_addr == `DDTF_OFF_IRQ_MASK) begin
            mask_next = i_wdata[`DDTF_EVT_W-1:0];
        end
        if (i_we && i_addr == `DDTF_OFF_IRQ_STS) begin
            sts_next = sts_next & ~i_wdata[`DDTF_EVT_W-1:0];
        end
        // New events after the clear so they are never lost
        sts_next = sts_next | evt;
        irq_next = |(sts_next & mask_next);
        rdata_next = `DDTF_WORD_RESET;
        if (i_re) begin
            unique case (i_addr)
                `DDTF_OFF_STATUS: begin
                    rdata_next[`DDTF_BIT_RX_LIVE] = rx_live_reg;
                    rdata_next[`DDTF_BIT_TX_LIVE] = tx_live_reg;
                    rdata_next[`DDTF_BIT_RX_LAT] = rx_lat_reg;
                    rdata_next[`DDTF_BIT_TX_LAT] = tx_lat_reg;
                    rdata_next[`DDTF_MODE_MSB:`DDTF_MODE_LSB] = mode_reg;
                end
                `DDTF_OFF_TX_WORD: rdata_next = tx_word;
                `DDTF_OFF_IRQ_STS: rdata_next[`DDTF_EVT_W-1:0] = sts_reg;
                `DDTF_OFF_IRQ_MASK: rdata_next[`DDTF_EVT_W-1:0] = mask_reg;
                default: rdata_next = `DDTF_WORD_RESET;
            endcase
        end
    end

    // All state flops except the data words
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rx_live_reg <= 1'b0;
            tx_live_reg <= 1'b0;
            rx_lat_reg <= 1'b0;
            tx_lat_reg <= 1'b0;
            mode_reg <= `DDTF_MODE_RESET;
            sts_reg <= `DDTF_EVT_RESET;
            mask_reg <= `DDTF_EVT_RESET;
            rdata_reg <= `DDTF_WORD_RESET;
            irq_reg <= 1'b0;
        end else begin
            rx_live_reg <= rx_live_next;
            tx_live_reg <= tx_live_next;
            rx_lat_reg <= rx_lat_next;
            tx_lat_reg <= tx_lat_next;
            mode_reg <= mode_next;
            sts_reg <= sts_next;
            mask_reg <= mask_next;
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_core_rx_word = rx_word;
    assign o_rx_full_live = rx_live_reg;
    assign o_tx_full_live = tx_live_reg;
    assign o_irq = irq_reg;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    AST_LAT_HOLD: assert property (
        nb && !sts_rd && !rx_wr |=> $stable(rx_lat_reg))
        else $error("latched rx full moved without a debugger access");
    AST_CORE_RX_CLEAR: assert property (
        nb && i_core_rx_rd && !rx_wr && !sts_rd && rx_lat_reg
        |=> !o_rx_full_live && rx_lat_reg)
        else $error("core rx read did not clear live or lost latched");
    AST_RX_IGNORED: assert property (
        nb && rx_wr && rx_lat_reg |=> $stable(rx_word))
        else $error("debugger rx write taken while latched full");
    AST_STS_RX: assert property (
        nb && sts_rd |=> rx_lat_reg == $past(rx_live_reg))
        else $error("status read did not copy live rx full");
    AST_RXW_REFRESH: assert property (
        nb && rx_wr |=> rx_lat_reg == o_rx_full_live)
        else $error("rx write did not refresh latched rx full");
    AST_STS_TX: assert property (
        nb && sts_rd |=> tx_lat_reg == $past(tx_live_reg))
        else $error("status read did not copy live tx full");
    AST_TXR_REFRESH: assert property (
        nb && tx_rd |=> tx_lat_reg == o_tx_full_live)
        else $error("tx read did not refresh latched tx full");
    // Each side is checked on its own so neither needs the other to fire
    AST_RX_SET: assert property (
        rx_accept |=> o_rx_full_live && rx_word == $past(i_wdata))
        else $error("accepted rx write did not set live rx full");
    AST_TX_SET: assert property (
        i_core_tx_wr |=> o_tx_full_live && tx_word == $past(i_core_tx_word))
        else $error("core tx write did not set live tx full");
    AST_TX_CLEAR: assert property (
        tx_take && !i_core_tx_wr
        |=> !o_tx_full_live && o_rdata == $past(tx_word))
        else $error("taken tx read did not clear live tx full");
endmodule

`default_nettype wire

//--- tb/ddtf_dbg_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "ddtf_consts.svh"

// Debugger side of the register port, changed only after rising edges
module ddtf_dbg_model (
    input wire logic i_clk,
    output ddtf_pkg::ddtf_addr_type o_addr,
    output ddtf_pkg::ddtf_word_type o_wdata,
    output logic o_we,
    output logic o_re,
    input wire ddtf_pkg::ddtf_word_type i_rdata
);
    import ddtf_pkg::*;

    // Idle bus at time zero
    initial begin
        o_addr = 8'h00;
        o_wdata = 32'h0000_0000;
        o_we = 1'b0;
        o_re = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One-cycle write; stale data inverted so nothing leans on it
    task automatic wr(input ddtf_addr_type a, input ddtf_word_type d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_we <= 1'b1;
        @(posedge i_clk);
        o_we <= 1'b0;
        o_wdata <= ~d;
        #1;
    endtask

    // One-cycle read; data sampled in the only cycle it stands
    task automatic rd(input ddtf_addr_type a, output ddtf_word_type d);
        @(posedge i_clk);
        o_addr <= a;
        o_re <= 1'b1;
        @(posedge i_clk);
        o_re <= 1'b0;
        #1;
        d = i_rdata;
    endtask

    // Well-behaved transfer: status first, write only when seen empty
    task automatic send_rx(input ddtf_word_type d, output logic ok);
        ddtf_word_type s;
        rd(`DDTF_OFF_STATUS, s);
        ok = !s[`DDTF_BIT_RX_LAT];
        if (ok) begin
            wr(`DDTF_OFF_RX_WORD, d);
        end
    endtask
endmodule
`default_nettype wire

//--- tb/tb_ddtf_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ddtf_consts.svh"

`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    err_total++; $display("mismatch %s exp %h got %h", n, e, g); end end

module tb_ddtf_top;
    import ddtf_pkg::*;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_core_rx_rd = 1'b0;
    logic i_core_tx_wr = 1'b0;
    ddtf_word_type i_core_tx_word = 32'h0000_0000;
    ddtf_addr_type addr;
    ddtf_word_type wdata, rdata, core_rx_word, d;
    logic we, re, rx_live, tx_live, irq, ok;
    int err_total = 0;
    int comparisons = 0;

    // 40 MHz clock
    initial begin
        forever #12.5 i_clk = ~i_clk;
    end

    ddtf_top u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(addr),
        .i_wdata(wdata), .i_we(we), .i_re(re), .o_rdata(rdata),
        .i_core_rx_rd(i_core_rx_rd), .o_core_rx_word(core_rx_word),
        .i_core_tx_wr(i_core_tx_wr), .i_core_tx_word(i_core_tx_word),
        .o_rx_full_live(rx_live), .o_tx_full_live(tx_live), .o_irq(irq));

    ddtf_dbg_model u_dbg (.i_clk(i_clk), .o_addr(addr), .o_wdata(wdata),
        .o_we(we), .o_re(re), .i_rdata(rdata));

    ////////////////////////////////////////////////////////////////////////
    // Core-side one-cycle pulse
    task automatic core_op(input logic r, input logic w,
        input ddtf_word_type x);
        @(posedge i_clk);
        i_core_rx_rd <= r;
        i_core_tx_wr <= w;
        i_core_tx_word <= x;
        @(posedge i_clk);
        i_core_rx_rd <= 1'b0;
        i_core_tx_wr <= 1'b0;
        #1;
    endtask

    // Bounded wait for the interrupt level
    task automatic wait_irq(input logic e);
        for (int n = 0; n < 8 && irq !== e; n++) begin
            @(posedge i_clk);
            #1;
        end
        `CHK("irq", e, irq)
        if (irq !== e) print_verdict();
    endtask

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (8) @(posedge i_clk);
        i_rstn <= 1'b1;
        u_dbg.rd(`DDTF_OFF_STATUS, d);
        `CHK("status_rst", 32'h0000_0000, d)
        $display("test reset done");
        // Receive side: drain by core, then a blind second write
        u_dbg.wr(`DDTF_OFF_RX_WORD, 32'h1234_abcd);
        `CHK("rx_live", 1'b1, rx_live)
        core_op(1'b1, 1'b0, 32'h0000_0000);
        `CHK("rx_clr", 1'b0, rx_live)
        u_dbg.wr(`DDTF_OFF_RX_WORD, 32'h5555_0000);
        `CHK("rx_keep", 32'h1234_abcd, core_rx_word)
        `CHK("rx_stay", 1'b0, rx_live)
        u_dbg.send_rx(32'h0bad_f00d, ok);
        `CHK("rx_ok", 1'b1, ok)
        `CHK("rx_new", 32'h0bad_f00d, core_rx_word)
        $display("test rx done");
        // Transmit side: refused blind second read
        core_op(1'b0, 1'b1, 32'hcafe_0001);
        u_dbg.rd(`DDTF_OFF_STATUS, d);
        u_dbg.rd(`DDTF_OFF_STATUS, d);
        `CHK("status_full", 32'h0000_000f, d)
        u_dbg.rd(`DDTF_OFF_TX_WORD, d);
        `CHK("tx_word", 32'hcafe_0001, d)
        `CHK("tx_clr", 1'b0, tx_live)
        core_op(1'b0, 1'b1, 32'hcafe_0002);
        u_dbg.rd(`DDTF_OFF_TX_WORD, d);
        `CHK("tx_refuse", 1'b1, tx_live)
        $display("test tx done");
        // Interrupts and unmapped space
        u_dbg.rd(`DDTF_OFF_IRQ_STS, d);
        `CHK("irq_sts", 32'h0000_000f, d)
        wait_irq(1'b0);
        u_dbg.wr(`DDTF_OFF_IRQ_MASK, 32'h0000_0001);
        wait_irq(1'b1);
        u_dbg.wr(`DDTF_OFF_IRQ_STS, 32'h0000_0001);
        wait_irq(1'b0);
        u_dbg.rd(`DDTF_OFF_IRQ_STS, d);
        `CHK("irq_w1c", 32'h0000_000e, d)
        u_dbg.wr(8'h14, 32'hffff_ffff);
        u_dbg.rd(8'h14, d);
        `CHK("unmapped", 32'h0000_0000, d)
        $display("test irq done");
        // Latched copy after a drain, then blocking-mode gating on live
        core_op(1'b1, 1'b0, 32'h0000_0000);
        u_dbg.rd(`DDTF_OFF_STATUS, d);
        `CHK("sts_lat_kept", 32'h0000_000e, d)
        u_dbg.rd(`DDTF_OFF_STATUS, d);
        `CHK("sts_copy", 32'h0000_000a, d)
        u_dbg.wr(`DDTF_OFF_RX_WORD, 32'h7777_0001);
        `CHK("rx_after_sts", 32'h7777_0001, core_rx_word)
        u_dbg.wr(`DDTF_OFF_STATUS, 32'h0000_0010);
        core_op(1'b1, 1'b0, 32'h0000_0000);
        u_dbg.wr(`DDTF_OFF_RX_WORD, 32'h7777_0002);
        `CHK("rx_blocking", 32'h7777_0002, core_rx_word)
        u_dbg.rd(`DDTF_OFF_STATUS, d);
        `CHK("sts_blocking", 32'h0000_001f, d)
        $display("test mode done");
        print_verdict();
    end
endmodule
`default_nettype wire
